// file: common/cfg_port_pkg.sv
package cfg_port_pkg;

    // Serial framing
    localparam int FRAME_BITS = 24;
    localparam int COUNT_BITS = 10;
    localparam logic [7:0] CMD_READ = 8'hfe;
    localparam logic [7:0] CMD_FETCH = 8'hff;

    // Bank-0 register addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CHAIN = 8'h01;
    localparam logic [7:0] ADDR_BANK = 8'h03;
    localparam logic [7:0] ADDR_SETUP = 8'h04;
    localparam logic [7:0] ADDR_COPY = 8'h06;

    // Bank-1 register that marks setup complete
    localparam logic [7:0] ADDR_INIT_DONE = 8'h37;
    localparam logic [15:0] INIT_DONE_VALUE = 16'h0005;

    // Controller waits in the setup sequence, in 25 ns sys_clk cycles
    localparam int WAIT_SETTLE_CYCLES = 400;
    localparam int WAIT_CAL_CYCLES = 40000;

    // Field positions in port_control
    localparam int CTRL_SOFT_RESET = 0;
    localparam int CTRL_READ_EN = 1;
    localparam int CTRL_LEGACY = 2;

    // Field position of chain_count in chain_length_cfg
    localparam int CHAIN_LSB = 2;
    localparam int CHAIN_MSB = 6;

    // bank_pointer encodings
    localparam logic [7:0] SEL_BANK1 = 8'h02;
    localparam logic [7:0] SEL_BANK2 = 8'h10;

    // Reset values
    localparam logic [15:0] RST_CONTROL = 16'h0000;
    localparam logic [15:0] RST_CHAIN = 16'h0000;
    localparam logic [15:0] RST_BANK = 16'h0002;
    localparam logic [15:0] RST_SETUP = 16'h0000;
    localparam logic [15:0] RST_BANKED = 16'h0000;

    // One 24-bit command word as it sits in the shifter
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } cfg_word_t;

    // Decoded target of a read or write
    typedef struct packed {
        logic valid;
        logic idx;
    } bank_hit_t;

endpackage

// file: core/chain_shift.sv
`timescale 1ns/10ps
`default_nettype none

module chain_shift #(
    parameter int WIDTH = 24
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic shiftEn,
    input wire logic serialIn,
    input wire logic loadEn,
    input wire logic [WIDTH-1:0] loadWord,
    output logic [WIDTH-1:0] word
);

    logic [WIDTH-1:0] word_q;

    // Load and shift never coincide: load only at frame end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            word_q <= '0;
        end else if (loadEn) begin
            word_q <= loadWord;
        end else if (shiftEn) begin
            word_q <= {word_q[WIDTH-2:0], serialIn};
        end
    end

    assign word = word_q;

endmodule

`default_nettype wire

// file: core/banked_config_port.sv
`timescale 1ns/10ps
`default_nettype none

module banked_config_port
    import cfg_port_pkg::*;
#(
    parameter int BANK_DEPTH = 256
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic legacyMode,
    output logic readbackPermit,
    output logic [4:0] chainCount,
    output logic deviceReady
);

    logic [2:0] csSync;
    logic [2:0] sclkSync;
    logic [1:0] sdiSync;
    logic csActive;
    logic frameEnd;
    logic shiftEn;
    logic [COUNT_BITS-1:0] bitCount_q;
    logic [23:0] shiftWord;
    cfg_word_t rxWord;
    logic frameDone;
    logic readReq;
    logic writeReq;
    logic [7:0] readAddr;
    logic [15:0] readData;
    logic [23:0] loadWord;
    logic [15:0] control_q;
    logic [15:0] chain_q;
    logic [15:0] bank_q;
    logic [15:0] setup_q;
    logic [15:0] banked_q [2][BANK_DEPTH];
    logic sdo_q;
    logic ready_q;
    bank_hit_t readHit;
    bank_hit_t writeHit;

    function automatic logic isBank0(input logic [7:0] a);
        return (a == ADDR_CONTROL) || (a == ADDR_CHAIN) || (a == ADDR_BANK) ||
               (a == ADDR_SETUP) || (a == ADDR_COPY);
    endfunction

    function automatic bank_hit_t bankOf(input logic [7:0] sel, input logic [7:0] a);
        bank_hit_t h;
        h.valid = !isBank0(a) && ((sel == SEL_BANK1) || (sel == SEL_BANK2));
        h.idx = (sel == SEL_BANK2);
        return h;
    endfunction

    // Pins come from the controller's domain
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            csSync <= 3'h7;
            sclkSync <= 3'h0;
            sdiSync <= 2'h0;
        end else begin
            csSync <= {csSync[1:0], csN};
            sclkSync <= {sclkSync[1:0], sclk};
            sdiSync <= {sdiSync[0], sdi};
        end
    end

    assign csActive = !csSync[1];
    assign frameEnd = csSync[1] && !csSync[2];
    assign shiftEn = csActive && sclkSync[1] && !sclkSync[2];

    // Saturating, so long chained frames never wrap back under one word
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bitCount_q <= '0;
        end else if (!csActive) begin
            bitCount_q <= '0;
        end else if (shiftEn && (bitCount_q != '1)) begin
            bitCount_q <= bitCount_q + COUNT_BITS'(1);
        end
    end

    chain_shift #(
        .WIDTH(FRAME_BITS)
    ) u_shift (
        .sys_clk(sys_clk),
        .rst(rst),
        .shiftEn(shiftEn),
        .serialIn(sdiSync[1]),
        .loadEn(readReq),
        .loadWord(loadWord),
        .word(shiftWord)
    );

    always_comb begin
        rxWord = cfg_word_t'(shiftWord);
        // Short frames are dropped: nothing complete to decode
        frameDone = frameEnd && (bitCount_q >= COUNT_BITS'(FRAME_BITS));
        // Mode and read permit select the decode
        if (control_q[CTRL_LEGACY]) begin
            // Legacy read answers in the next frame
            readReq = frameDone && control_q[CTRL_READ_EN] && (rxWord.addr != ADDR_CONTROL);
            readAddr = rxWord.addr;
            // Permit blocks writes, except to the control word
            writeReq = frameDone && !readReq;
        end else begin
            // Read command and fill words are not writes
            readReq = frameDone && (rxWord.addr == CMD_READ);
            readAddr = rxWord.data[7:0];
            writeReq = frameDone && !readReq && (rxWord.addr != CMD_FETCH);
        end
        readHit = bankOf(bank_q[7:0], readAddr);
        writeHit = bankOf(bank_q[7:0], rxWord.addr);
        // Copy of the write-only control word
        case (readAddr)
            ADDR_CHAIN: readData = chain_q;
            ADDR_BANK: readData = bank_q;
            ADDR_SETUP: readData = setup_q;
            ADDR_COPY: readData = control_q;
            default: begin
                if (readHit.valid) begin
                    readData = banked_q[readHit.idx][readAddr];
                end else begin
                    readData = 16'h0000;
                end
            end
        endcase
        // Address and data go back out first in the next frame
        loadWord = {readAddr, readData};
    end

    // Register storage; soft reset restores all defaults
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            control_q <= RST_CONTROL;
            chain_q <= RST_CHAIN;
            bank_q <= RST_BANK;
            setup_q <= RST_SETUP;
            for (int b = 0; b < 2; b++) begin
                for (int i = 0; i < BANK_DEPTH; i++) begin
                    banked_q[b][i] <= RST_BANKED;
                end
            end
        end else if (writeReq) begin
            // Bank-0 addresses decoded ahead of the bank pointer
            case (rxWord.addr)
                ADDR_CONTROL: begin
                    if (rxWord.data[CTRL_SOFT_RESET]) begin
                        control_q <= RST_CONTROL;
                        chain_q <= RST_CHAIN;
                        bank_q <= RST_BANK;
                        setup_q <= RST_SETUP;
                        for (int b = 0; b < 2; b++) begin
                            for (int i = 0; i < BANK_DEPTH; i++) begin
                                banked_q[b][i] <= RST_BANKED;
                            end
                        end
                    end else begin
                        control_q <= rxWord.data;
                    end
                end
                ADDR_CHAIN: chain_q <= rxWord.data;
                ADDR_BANK: bank_q <= rxWord.data;
                ADDR_SETUP: setup_q <= rxWord.data;
                ADDR_COPY: begin
                end
                default: begin
                    if (writeHit.valid && (9'(rxWord.addr) < 9'(BANK_DEPTH))) begin
                        banked_q[writeHit.idx][rxWord.addr] <= rxWord.data;
                    end
                end
            endcase
        end
    end

    // Output flops; sdo lags the shifter by one sys_clk, well inside a bit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sdo_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            sdo_q <= shiftWord[FRAME_BITS-1];
            ready_q <= (banked_q[0][ADDR_INIT_DONE] == INIT_DONE_VALUE);
        end
    end

    assign sdo = sdo_q;
    assign legacyMode = control_q[CTRL_LEGACY];
    assign readbackPermit = control_q[CTRL_READ_EN];
    assign chainCount = chain_q[CHAIN_MSB:CHAIN_LSB];
    assign deviceReady = ready_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence frameTaken;
        frameDone && !readReq;
    endsequence

    sequence readTaken;
        readReq ##1 1'b1;
    endsequence

    a_shift_entry: assert property (shiftEn |=> shiftWord[0] == $past(sdiSync[1]))
        else $error("Serial input bit not captured");
    a_shift_delay: assert property (shiftEn && !readReq
            |=> shiftWord[23:1] == $past(shiftWord[22:0]))
        else $error("Delay line did not advance by one place");
    a_read_load: assert property (readTaken
            |-> shiftWord == {$past(readAddr), $past(readData)})
        else $error("Output shifter not loaded on read command");
    a_chain_read_cmd: assert property (frameDone && !legacyMode && rxWord.addr == CMD_READ
            |-> (readReq && !writeReq) ##1 (shiftWord[23:16] == $past(rxWord.data[7:0])))
        else $error("Chained read command not decoded");
    a_write_blocked: assert property (frameDone && legacyMode && readbackPermit &&
            rxWord.addr == ADDR_SETUP |=> $stable(setup_q))
        else $error("Write taken while readback permitted");
    a_legacy_read: assert property (frameDone && legacyMode && readbackPermit &&
            rxWord.addr != ADDR_CONTROL |-> readReq ##1 shiftWord[23:16] == $past(rxWord.addr))
        else $error("Legacy read did not load addressed value");
    a_bank0_reach: assert property (frameTaken ##0 (rxWord.addr == ADDR_SETUP)
            |=> setup_q == $past(rxWord.data))
        else $error("Bank-0 write lost under bank pointer");
    a_copy_read: assert property (readReq && readAddr == ADDR_COPY
            |=> shiftWord[15:0] == $past(control_q))
        else $error("Control copy mismatch");
    a_chain_field: assert property (writeReq && rxWord.addr == ADDR_CHAIN
            |=> chainCount == $past(rxWord.data[CHAIN_MSB:CHAIN_LSB]))
        else $error("Chain count field misplaced");
    a_soft_reset: assert property (writeReq && rxWord.addr == ADDR_CONTROL &&
            rxWord.data[CTRL_SOFT_RESET] |=> bank_q == RST_BANK && !legacyMode)
        else $error("Soft reset did not restore defaults");
    a_bank_store: assert property (writeReq && writeHit.valid && rxWord.addr == ADDR_INIT_DONE
            && !writeHit.idx ##1 1'b1 |-> banked_q[0][ADDR_INIT_DONE] == $past(rxWord.data))
        else $error("Banked register write lost");
    a_sdo_follow: assert property (##1 1'b1 |-> sdo == $past(shiftWord[23]))
        else $error("Serial output not from shifter MSB");

endmodule

`default_nettype wire

// file: tb/spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
    input wire logic sys_clk,
    output logic csN,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    output logic done,
    output logic [23:0] rxWord
);
    logic [47:0] rx;

    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        done = 1'b0;
        rxWord = 24'h000000;
    end

    task automatic frame(input logic [47:0] w, input int nBits);
        rx = 48'h0;
        @(posedge sys_clk) csN <= 1'b0;
        for (int i = nBits - 1; i >= 0; i--) begin
            @(posedge sys_clk) sdi <= w[i];
            repeat (3) @(posedge sys_clk);
            // Sample before the rise lands, sdo lags it
            rx = {rx[46:0], sdo};
            sclk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        csN <= 1'b1;
        // Released line shows the inverse, not a stale bit
        sdi <= ~sdi;
        rxWord <= rx[23:0];
        done <= 1'b1;
        @(posedge sys_clk) done <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask
endmodule

`default_nettype wire

// file: tb/tb_banked_config_port.sv
`timescale 1ns/10ps
`default_nettype none

module tb_banked_config_port;
    import cfg_port_pkg::*;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic csN, sclk, sdi, sdo, done, legacyMode, readbackPermit, deviceReady;
    logic [4:0] chainCount;
    logic [23:0] rxWord, w;
    logic [24:0] note;
    logic [24:0] expQ[$];
    logic [15:0] v, k, u;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    banked_config_port u_dut (.sys_clk(sys_clk), .rst(rst), .csN(csN), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .legacyMode(legacyMode), .readbackPermit(readbackPermit),
        .chainCount(chainCount), .deviceReady(deviceReady));

    spi_host_model u_host (.sys_clk(sys_clk), .csN(csN), .sclk(sclk), .sdi(sdi),
        .sdo(sdo), .done(done), .rxWord(rxWord));

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic flags(input logic lm, input logic rp, input logic [4:0] cc, input logic dr);
        check("legacyMode", {23'h0, lm}, {23'h0, legacyMode});
        check("readbackPermit", {23'h0, rp}, {23'h0, readbackPermit});
        check("chainCount", {19'h0, cc}, {19'h0, chainCount});
        check("deviceReady", {23'h0, dr}, {23'h0, deviceReady});
    endtask

    // Note is {compare, expected word on sdo}
    task automatic send(input logic [7:0] a, input logic [15:0] d, input logic [24:0] n);
        expQ.push_back(n);
        u_host.frame({24'h0, a, d}, 24);
    endtask

    task automatic cread(input logic [7:0] a, input logic [15:0] d);
        send(CMD_READ, {8'h00, a}, 25'h0);
        send(CMD_FETCH, {CMD_FETCH, CMD_FETCH}, {1'b1, a, d});
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        if (done === 1'b1 && expQ.size() > 0) begin
            note = expQ.pop_front();
            if (note[24] === 1'b1) check("sdo word", note[23:0], rxWord);
        end
    end

    // Ceiling above the roughly 95000 cycles the tests need, 1 ms waits included
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 99000) begin
            n_errors++;
            $display("timeout");
            stop_test();
        end
    end

    // Controller setup sequence, one device in the chain
    task automatic setup_seq(input logic [15:0] user);
        send(ADDR_BANK, {8'h00, SEL_BANK1}, 25'h0);
        send(8'hf6, 16'h0002, 25'h0);
        send(ADDR_SETUP, 16'h000b, 25'h0);
        send(ADDR_BANK, {8'h00, SEL_BANK2}, 25'h0);
        send(8'h12, 16'h0040, 25'h0);
        send(8'h13, 16'h8000, 25'h0);
        send(8'h0a, 16'h4000, 25'h0);
        repeat (WAIT_SETTLE_CYCLES) @(posedge sys_clk);
        send(8'h0a, 16'h0000, 25'h0);
        send(ADDR_BANK, {8'h00, SEL_BANK1}, 25'h0);
        send(8'hf6, 16'h0000, 25'h0);
        send(ADDR_BANK, {8'h00, SEL_BANK2}, 25'h0);
        send(8'h13, 16'h0000, 25'h0);
        send(8'h12, 16'h0000, 25'h0);
        send(8'h19, 16'h0e00, 25'h0);
        send(8'h1f, 16'h1800, 25'h0);
        send(ADDR_SETUP, 16'h0000, 25'h0);
        send(ADDR_BANK, {8'h00, SEL_BANK1}, 25'h0);
        send(8'h33, 16'h0030, 25'h0);
        send(8'hf4, 16'h0000, 25'h0);
        send(8'hf4, 16'h0002, 25'h0);
        repeat (WAIT_CAL_CYCLES) @(posedge sys_clk);
        send(8'hf4, 16'h0000, 25'h0);
        repeat (WAIT_CAL_CYCLES) @(posedge sys_clk);
        send(8'h33, 16'h0000, 25'h0);
        send(8'h0d, user, 25'h0);
        send(8'h33, 16'h2040, 25'h0);
        send(8'h34, 16'h0010, 25'h0);
        send(ADDR_INIT_DONE, INIT_DONE_VALUE, 25'h0);
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    initial begin
        void'($urandom(32'h5d7b));
        do_reset();
        flags(1'b0, 1'b0, 5'd0, 1'b0);
        cread(ADDR_BANK, RST_BANK);
        $display("test 1 done");
        v = 16'($urandom % 16);
        send(ADDR_SETUP, v, 25'h0);
        cread(ADDR_SETUP, v);
        $display("test 2 done");
        w = 24'($urandom);
        expQ.push_back({1'b1, w});
        u_host.frame({w, 24'hffffff}, 48);
        $display("test 3 done");
        k = 16'($urandom % 32);
        send(ADDR_CHAIN, k << CHAIN_LSB, 25'h0);
        flags(1'b0, 1'b0, k[4:0], 1'b0);
        cread(ADDR_CHAIN, k << CHAIN_LSB);
        $display("test 4 done");
        send(ADDR_BANK, {8'h00, SEL_BANK2}, 25'h0);
        send(ADDR_INIT_DONE, INIT_DONE_VALUE, 25'h0);
        flags(1'b0, 1'b0, k[4:0], 1'b0);
        cread(ADDR_SETUP, v);
        send(ADDR_BANK, {8'h00, SEL_BANK1}, 25'h0);
        cread(ADDR_INIT_DONE, 16'h0000);
        send(ADDR_INIT_DONE, INIT_DONE_VALUE, 25'h0);
        flags(1'b0, 1'b0, k[4:0], 1'b1);
        cread(ADDR_INIT_DONE, INIT_DONE_VALUE);
        $display("test 5 done");
        send(ADDR_CONTROL, 16'h0006, 25'h0);
        flags(1'b1, 1'b1, k[4:0], 1'b1);
        send(ADDR_COPY, 16'h0000, 25'h0);
        send(ADDR_SETUP, 16'h000f, {1'b1, ADDR_COPY, 16'h0006});
        send(ADDR_CONTROL, 16'h0004, {1'b1, ADDR_SETUP, v});
        flags(1'b1, 1'b0, k[4:0], 1'b1);
        $display("test 6 done");
        // Soft reset from legacy mode restores every default
        send(ADDR_CONTROL, 16'h0001, 25'h0);
        flags(1'b0, 1'b0, 5'd0, 1'b0);
        cread(ADDR_SETUP, RST_SETUP);
        $display("test 7 done");
        do_reset();
        flags(1'b0, 1'b0, 5'd0, 1'b0);
        cread(ADDR_CHAIN, RST_CHAIN);
        cread(ADDR_BANK, RST_BANK);
        $display("test 8 done");
        u = 16'($urandom);
        setup_seq(u);
        flags(1'b0, 1'b0, 5'd0, 1'b1);
        cread(8'h0d, u);
        cread(ADDR_SETUP, 16'h0000);
        send(8'hc1, 16'($urandom), 25'h0);
        send(8'hc2, 16'($urandom), 25'h0);
        send(8'hc3, 16'($urandom), 25'h0);
        send(8'hc0, 16'($urandom), 25'h0);
        send(8'hc4, 16'($urandom), 25'h0);
        send(8'hc5, 16'($urandom), 25'h0);
        send(ADDR_BANK, {8'h00, SEL_BANK2}, 25'h0);
        cread(8'h1f, 16'h1800);
        $display("test 9 done");
        stop_test();
    end
endmodule

`default_nettype wire
